/* File: inc/cgpm_pkg.sv */
package cgpm_pkg;
    localparam logic [1:0] CLOCK_OUTPUT_PIN_OFF = 2'h0;
    localparam logic [1:0] CLOCK_OUTPUT_PIN_LOW = 2'h1;
    localparam logic [1:0] CLOCK_OUTPUT_PIN_DIV8 = 2'h2;
    localparam logic [1:0] CLOCK_OUTPUT_PIN_DIV32 = 2'h3;
    localparam logic [4:0] DIV8_HALF = 5'h3;
    localparam logic [4:0] DIV32_HALF = 5'hF;
    localparam int STOP_DET_NS = 32;
    localparam int CLK_NS = 4;
    localparam int STOP_DET_CYC = STOP_DET_NS / CLK_NS;
    localparam logic [3:0] STOP_DET_LIM = 4'(STOP_DET_CYC);
    localparam int SWINT_MAX = 63;
    localparam logic [15:0] FREQ_STAT_RST = 16'h0000;
    typedef enum logic [2:0]
    {
        PM_RUN = 3'h1,
        PM_WAIT = 3'h2,
        PM_STOP = 3'h4
    } cgpm_mode_type;
endpackage

/* File: rtl/cgpm_div.sv */
module cgpm_div
    import cgpm_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic run, // Count enable
    input wire logic [4:0] half, // Half-period minus one
    output logic q // Divided clock level
);
    logic [4:0] cnt_r, cnt_nxt;
    logic q_nxt;
    always_comb
    begin
        cnt_nxt = cnt_r;
        q_nxt = q;
        if (run)
        begin
            if (cnt_r >= half)
            begin
                cnt_nxt = 5'h00;
                q_nxt = ~q;
            end
            else
            begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt_r <= 5'h00;
            q <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            q <= q_nxt;
        end
    end
endmodule

/* File: rtl/cgpm_top.sv */
module cgpm_top
    import cgpm_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic rst, // Hardware reset, sync high
    input wire logic osc_hold_off_option, // Keep on-chip osc off after reset
    input wire logic onchip_osc_start_bit, // Start on-chip osc
    input wire logic wdt_source_onchip_bit, // Watchdog counts on-chip osc
    input wire logic base_clock_source_select, // 0 selects PLL as base clock
    input wire logic pll_stop_bit, // Requests PLL stop
    input wire logic pll_operating_mode_bit, // 0 lock-in, 1 self-oscillating
    input wire logic main_osc_disable_bit, // Stops main oscillator
    input wire logic main_clk_tick, // Activity seen from main oscillator
    input wire logic pll_ref_tick, // PLL output edge for frequency count
    input wire logic wait_req, // Enter wait mode
    input wire logic stop_req, // Enter stop mode
    input wire logic nmi, // Non-maskable interrupt
    input wire logic lvd_irq, // Low voltage detection interrupt
    input wire logic periph_irq, // Peripheral interrupt request
    input wire logic [7:0] periph_irq_num, // Its software interrupt number
    input wire logic osc_stop_clr, // Clears stop-detect flag
    input wire logic [1:0] clock_output_pin_sel, // Clock output source
    input wire logic low_speed_clk, // Low-speed clock level
    output logic onchip_osc_run, // On-chip oscillator running
    output logic onchip_osc_ready, // On-chip clock usable
    output logic main_osc_run, // Main oscillator enabled
    output logic sub_osc_run, // Sub oscillator enabled
    output logic pll_run, // PLL oscillating
    output logic pll_self_osc, // PLL in self-oscillating mode
    output logic base_clk_en, // Base clock gate
    output logic cpu_clk_en, // CPU clock gate
    output logic periph_clk_en, // Peripheral bus clock gate
    output logic wdt_clk_en, // Watchdog count gate
    output logic osc_stop_flag, // Main oscillator stop detected
    output logic [15:0] pll_freq_stat, // PLL frequency status count
    output logic clock_output_pin, // Clock output
    output logic [2:0] power_mode // Current power mode, one-hot
);
    cgpm_mode_type mode_r, mode_nxt;
    logic osc_r, osc_nxt;
    logic flag_nxt;
    logic [3:0] idle_r, idle_nxt;
    logic [15:0] freq_nxt;
    logic mode_bit_d;
    logic pll_live, main_live, wake, div8, div32, pin_nxt;

    function automatic logic wake_src(input logic n, input logic l, input logic p,
                                      input logic [7:0] num);
        wake_src = n | l | (p & (num <= 8'(SWINT_MAX)));
    endfunction

    assign wake = wake_src(nmi, lvd_irq, periph_irq, periph_irq_num);
    assign pll_live = (~pll_stop_bit | ~base_clock_source_select) & (mode_r != PM_STOP);
    assign main_live = ~main_osc_disable_bit & (mode_r != PM_STOP);

    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            PM_RUN:
            begin
                if (stop_req)
                    mode_nxt = PM_STOP;
                else if (wait_req)
                    mode_nxt = PM_WAIT;
            end
            PM_WAIT:
            begin
                if (wake | periph_irq)
                    mode_nxt = PM_RUN;
            end
            PM_STOP:
            begin
                if (wake)
                    mode_nxt = PM_RUN;
            end
            default: mode_nxt = PM_RUN;
        endcase
    end

    always_comb
    begin
        // Start is immediate: no stabilisation counter is kept
        osc_nxt = osc_r | onchip_osc_start_bit | wdt_source_onchip_bit;
        flag_nxt = osc_stop_flag;
        idle_nxt = idle_r;
        if (main_clk_tick | main_osc_disable_bit)
            idle_nxt = 4'h0;
        else if (idle_r != STOP_DET_LIM)
            idle_nxt = idle_r + 4'h1;
        if (osc_stop_clr)
            flag_nxt = 1'b0;
        // Set wins over a same-cycle clear
        if (idle_nxt == STOP_DET_LIM)
            flag_nxt = 1'b1;
        freq_nxt = pll_freq_stat;
        if (pll_operating_mode_bit & ~mode_bit_d)
            freq_nxt = FREQ_STAT_RST;
        // Counting resumes straight after a main restart, so an overshoot shows here
        else if (pll_live & main_live & (idle_r != STOP_DET_LIM) & pll_ref_tick)
            freq_nxt = pll_freq_stat + 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mode_r <= PM_RUN;
            osc_r <= 1'b0;
            idle_r <= 4'h0;
            osc_stop_flag <= 1'b0;
            pll_freq_stat <= FREQ_STAT_RST;
            mode_bit_d <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            osc_r <= osc_nxt;
            idle_r <= idle_nxt;
            osc_stop_flag <= flag_nxt;
            pll_freq_stat <= freq_nxt;
            mode_bit_d <= pll_operating_mode_bit;
        end
    end

    // Option sampled each cycle after reset release; 0 lets the osc run freely
    logic osc_on;
    assign osc_on = (osc_r | ~osc_hold_off_option) & (mode_r != PM_STOP);

    cgpm_div u_div8
    (
        .mclk(mclk),
        .rst(rst),
        .run(periph_clk_en),
        .half(DIV8_HALF),
        .q(div8)
    );
    cgpm_div u_div32
    (
        .mclk(mclk),
        .rst(rst),
        .run(periph_clk_en),
        .half(DIV32_HALF),
        .q(div32)
    );

    always_comb
    begin
        case (clock_output_pin_sel)
            CLOCK_OUTPUT_PIN_LOW: pin_nxt = low_speed_clk;
            CLOCK_OUTPUT_PIN_DIV8: pin_nxt = div8;
            CLOCK_OUTPUT_PIN_DIV32: pin_nxt = div32;
            default: pin_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            onchip_osc_run <= 1'b0;
            onchip_osc_ready <= 1'b0;
            main_osc_run <= 1'b0;
            sub_osc_run <= 1'b0;
            pll_run <= 1'b0;
            pll_self_osc <= 1'b0;
            base_clk_en <= 1'b0;
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            wdt_clk_en <= 1'b0;
            clock_output_pin <= 1'b0;
            power_mode <= 3'h1;
        end
        else
        begin
            onchip_osc_run <= osc_on;
            onchip_osc_ready <= osc_on;
            main_osc_run <= main_live;
            sub_osc_run <= mode_r != PM_STOP;
            pll_run <= pll_live;
            pll_self_osc <= pll_operating_mode_bit;
            base_clk_en <= mode_r == PM_RUN;
            cpu_clk_en <= mode_r == PM_RUN;
            periph_clk_en <= mode_r == PM_RUN;
            wdt_clk_en <= (mode_r == PM_RUN) | ((mode_r == PM_WAIT) & wdt_source_onchip_bit);
            clock_output_pin <= pin_nxt;
            power_mode <= mode_r;
        end
    end

    a_wait_gates: assert property (@(posedge mclk) disable iff (rst)
        mode_r == PM_WAIT |=> !cpu_clk_en && !base_clk_en)
        else $error("cpu clock runs in wait");
    a_wdt_wait: assert property (@(posedge mclk) disable iff (rst)
        mode_r == PM_WAIT && wdt_source_onchip_bit |=> wdt_clk_en)
        else $error("watchdog stopped in wait");
    a_stop_halt: assert property (@(posedge mclk) disable iff (rst)
        mode_r == PM_STOP |=> !pll_run && !main_osc_run && !periph_clk_en)
        else $error("clock runs in stop");
    a_stop_exit: assert property (@(posedge mclk) disable iff (rst)
        mode_r == PM_STOP && nmi |=> mode_r == PM_RUN)
        else $error("nmi did not end stop");
    a_stop_hold: assert property (@(posedge mclk) disable iff (rst)
        mode_r == PM_STOP && !wake |=> mode_r == PM_STOP)
        else $error("stop left without cause");
    a_pll_base: assert property (@(posedge mclk) disable iff (rst)
        mode_r != PM_STOP && !base_clock_source_select |=> pll_run)
        else $error("pll stopped while base");
    a_osc_start: assert property (@(posedge mclk) disable iff (rst)
        mode_r == PM_RUN && onchip_osc_start_bit |=> ##1 onchip_osc_run)
        else $error("onchip osc not started");
    a_flag_set: assert property (@(posedge mclk) disable iff (rst)
        (!main_osc_disable_bit && !main_clk_tick) [*8] |=> osc_stop_flag)
        else $error("stop flag missing");
    a_freq_clr: assert property (@(posedge mclk) disable iff (rst)
        $rose(pll_operating_mode_bit) |=> pll_freq_stat == FREQ_STAT_RST)
        else $error("freq status not reset");
    a_freq_hold: assert property (@(posedge mclk) disable iff (rst)
        main_osc_disable_bit && !$rose(pll_operating_mode_bit) |=> $stable(pll_freq_stat))
        else $error("freq status moved");
    c_wait: cover property (@(posedge mclk) mode_r == PM_WAIT ##1 mode_r == PM_RUN);
    c_stop: cover property (@(posedge mclk) mode_r == PM_STOP ##1 mode_r == PM_RUN);
    c_flag: cover property (@(posedge mclk) $rose(osc_stop_flag));
    c_div32: cover property (@(posedge mclk) clock_output_pin_sel == CLOCK_OUTPUT_PIN_DIV32 && $rose(clock_output_pin));
endmodule

/* File: dv/cgpm_top_bench.sv */
module cgpm_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cgpm_pkg::*;
    logic mclk, rst, osc_hold_off_option, onchip_osc_start_bit, wdt_source_onchip_bit;
    logic base_clock_source_select, pll_stop_bit, pll_operating_mode_bit, main_osc_disable_bit;
    logic main_clk_tick, pll_ref_tick, wait_req, stop_req, nmi, lvd_irq, periph_irq;
    logic osc_stop_clr, low_speed_clk, onchip_osc_run, onchip_osc_ready, main_osc_run;
    logic sub_osc_run, pll_run, pll_self_osc, base_clk_en, cpu_clk_en, periph_clk_en;
    logic wdt_clk_en, osc_stop_flag, clock_output_pin;
    logic [7:0] periph_irq_num;
    logic [1:0] clock_output_pin_sel;
    logic [15:0] pll_freq_stat;
    logic [15:0] f;
    logic [2:0] power_mode;
    int errors;
    int compares;
    int n;

    cgpm_top cgpm_top_i (.mclk, .rst, .osc_hold_off_option, .onchip_osc_start_bit,
        .wdt_source_onchip_bit, .base_clock_source_select, .pll_stop_bit,
        .pll_operating_mode_bit, .main_osc_disable_bit, .main_clk_tick, .pll_ref_tick,
        .wait_req, .stop_req, .nmi, .lvd_irq, .periph_irq, .periph_irq_num, .osc_stop_clr,
        .clock_output_pin_sel, .low_speed_clk, .onchip_osc_run, .onchip_osc_ready, .main_osc_run,
        .sub_osc_run, .pll_run, .pll_self_osc, .base_clk_en, .cpu_clk_en, .periph_clk_en,
        .wdt_clk_en, .osc_stop_flag, .pll_freq_stat, .clock_output_pin, .power_mode);

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Inputs move 1 ns after the edge so no race with the design's sampling
    task tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task finish_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task do_reset();
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
        tick(10);
    endtask

    task t_onchip();
        check(power_mode, 16'h1);
        check(onchip_osc_run, 1'b0);
        onchip_osc_start_bit = 1'b1;
        tick(1);
        onchip_osc_start_bit = 1'b0;
        tick(2);
        check(onchip_osc_run, 1'b1);
        check(onchip_osc_ready, 1'b1);
        do_reset();
        check(onchip_osc_run, 1'b0);
        wdt_source_onchip_bit = 1'b1;
        tick(3);
        check(onchip_osc_run, 1'b1);
        $display("onchip done");
    endtask

    // Second pass has the watchdog on the bus clock, so it must stall too
    task t_wait();
        for (int w = 1; w >= 0; w--)
        begin
            wdt_source_onchip_bit = w[0];
            wait_req = 1'b1;
            tick(1);
            wait_req = 1'b0;
            tick(2);
            check(power_mode, 16'h2);
            check({base_clk_en, cpu_clk_en, periph_clk_en}, 3'h0);
            check(wdt_clk_en, w[0]);
            check({main_osc_run, sub_osc_run, pll_run, onchip_osc_run}, 4'hF);
            if (w == 1) nmi = 1'b1;
            else lvd_irq = 1'b1;
            tick(1);
            {nmi, lvd_irq} = 2'h0;
            tick(3);
            check({cpu_clk_en, power_mode}, 4'h9);
        end
        $display("wait done");
    endtask

    task t_stop();
        for (int k = 0; k < 6; k++)
        begin
            stop_req = 1'b1;
            tick(1);
            stop_req = 1'b0;
            tick(2);
            check(power_mode, 16'h4);
            check({cpu_clk_en, periph_clk_en, base_clk_en}, 3'h0);
            check({main_osc_run, sub_osc_run, pll_run, wdt_clk_en}, 4'h0);
            case (k)
                0: {periph_irq, periph_irq_num} = 9'h140;
                1: {periph_irq, periph_irq_num} = 9'h13F;
                2: {periph_irq, periph_irq_num} = 9'h100;
                3: nmi = 1'b1;
                4: lvd_irq = 1'b1;
                default: rst = 1'b1;
            endcase
            tick(1);
            {periph_irq, nmi, lvd_irq, rst} = 4'h0;
            tick(3);
            check(power_mode, (k == 0) ? 16'h4 : 16'h1);
        end
        tick(10);
        $display("stop done");
    endtask

    task t_osc_stop();
        main_clk_tick = 1'b0;
        tick(STOP_DET_CYC + 4);
        check(osc_stop_flag, 1'b1);
        main_clk_tick = 1'b1;
        main_osc_disable_bit = 1'b1;
        osc_stop_clr = 1'b1;
        tick(1);
        osc_stop_clr = 1'b0;
        tick(2);
        check(osc_stop_flag, 1'b0);
        check(main_osc_run, 1'b0);
        main_osc_disable_bit = 1'b0;
        tick(2);
        check(main_osc_run, 1'b1);
        $display("osc stop done");
    endtask

    task t_pll();
        pll_stop_bit = 1'b1;
        tick(4);
        check(pll_run, 1'b1);
        base_clock_source_select = 1'b1;
        tick(4);
        check(pll_run, 1'b0);
        {base_clock_source_select, pll_stop_bit} = 2'h0;
        pll_ref_tick = 1'b1;
        tick(10);
        pll_operating_mode_bit = 1'b1;
        pll_ref_tick = 1'b0;
        tick(3);
        check(pll_self_osc, 1'b1);
        check(pll_freq_stat, FREQ_STAT_RST);
        pll_ref_tick = 1'b1;
        main_osc_disable_bit = 1'b1;
        tick(4);
        f = pll_freq_stat;
        tick(6);
        check(pll_freq_stat, f);
        {main_osc_disable_bit, pll_operating_mode_bit} = 2'h0;
        tick(3);
        check(pll_self_osc, 1'b0);
        check(pll_freq_stat, f + 16'h0003);
        pll_ref_tick = 1'b0;
        $display("pll done");
    endtask

    task t_clock_output_pin();
        clock_output_pin_sel = CLOCK_OUTPUT_PIN_LOW;
        low_speed_clk = 1'b1;
        tick(3);
        check(clock_output_pin, 1'b1);
        low_speed_clk = 1'b0;
        tick(3);
        check(clock_output_pin, 1'b0);
        for (int s = 2; s < 4; s++)
        begin
            clock_output_pin_sel = CLOCK_OUTPUT_PIN_OFF;
            tick(1);
            check(clock_output_pin, 1'b0);
            clock_output_pin_sel = s[1:0];
            tick(4);
            n = 0;
            repeat (64)
            begin
                f[0] = clock_output_pin;
                tick(1);
                n += int'(f[0] != clock_output_pin);
            end
            check(16'(n), (s == 2) ? 16'h10 : 16'h4);
        end
        $display("clock_output_pin done");
    endtask

    initial
    begin
        {errors, compares} = 0;
        {rst, osc_hold_off_option, main_clk_tick} = 3'h7;
        {onchip_osc_start_bit, wdt_source_onchip_bit, base_clock_source_select} = 3'h0;
        {pll_stop_bit, pll_operating_mode_bit, main_osc_disable_bit, pll_ref_tick} = 4'h0;
        {wait_req, stop_req, nmi, lvd_irq, periph_irq, osc_stop_clr, low_speed_clk} = 7'h0;
        periph_irq_num = 8'h00;
        clock_output_pin_sel = CLOCK_OUTPUT_PIN_OFF;
        do_reset();
        t_onchip();
        t_wait();
        t_stop();
        t_osc_stop();
        t_pll();
        t_clock_output_pin();
        finish_test();
    end

    initial
    begin
        #20us;
        errors++;
        finish_test();
    end
endmodule
